// ==== hw/env_rate_if.sv ====
// Interface between the envelope controller and its step timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface env_rate_if;
    import voice_pkg::*;
    logic [PERIOD_W-1:0] period;   // Ticks per envelope step
    logic                restart;  // Clears the timer on phase change
    logic                tick;     // Oscillator tick enable
    logic                step;     // One-cycle step pulse

    modport ctrl  (output period, output restart, output tick,
                   input step);
    modport timer (input period, input restart, input tick,
                   output step);
endinterface : env_rate_if

// ==== hw/env_step_timer.sv ====
// Envelope step timer: counts oscillator ticks and pulses once per
// programmed period.
// Assumes period is at least one and stays stable within a phase.
`timescale 1ns/1ps
module env_step_timer
    import voice_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Controller side
    env_rate_if.timer rate
);

    logic [PERIOD_W-1:0] count_ff;
    logic                step_ff;

    // Count ticks; a restart drops any partial step
    always_ff @(posedge clk) begin
        if (!rst_n || rate.restart) begin
            count_ff <= '0;
            step_ff  <= 1'b0;
        end else begin
            step_ff <= 1'b0;
            if (rate.tick) begin
                if (count_ff >= rate.period - PERIOD_W'(1)) begin
                    count_ff <= '0;
                    step_ff  <= 1'b1;
                end else begin
                    count_ff <= count_ff + PERIOD_W'(1);
                end
            end
        end
    end

    assign rate.step = step_ff;

endmodule : env_step_timer

// ==== hw/tone_voice_envelope.sv ====
// One tone voice: oscillator, four waveforms and a loudness envelope,
// set up through byte registers at a fixed memory address.
// Assumes the host write strobe is synchronous to clk.
//
// Function
// - The frequency word is 256 times register 1 plus register 0 and tone rate follows it linearly.
// - Each register answers at base address 54272 plus its register number.
// - The attack code is four bits and picks a rise time of about 2 ms to 8 s.
// - The decay code is four bits and picks a fall time to sustain of 6 ms to 24 s.
// - Register 5 holds attack in its upper nibble and decay in its lower nibble.
// - The sustain code maps linearly from 0% to 100% of envelope peak.
// - Release falls from sustain to zero with the same timing range as decay.
// - Register 6 holds sustain in its upper nibble and release in its lower nibble.
// - The voice offers triangle, sawtooth, pulse and a random noise waveform.
`timescale 1ns/1ps
module tone_voice_envelope
    import voice_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Host write port
    input  wire logic               wrEn,
    input  wire logic [15:0]        wrAddr,
    input  wire logic [7:0]         wrData,
    // Voice output
    output logic [7:0]              sampleOut,
    output logic [LEVEL_W-1:0]      envLevel,
    output logic                    envActive
);

    // Register file
    logic [7:0]  noteLowByte_ff;
    logic [7:0]  noteHighByte_ff;
    logic [7:0]  pwLow_ff;
    logic [7:0]  pwHigh_ff;
    logic [7:0]  control_ff;
    logic [7:0]  attackDecay_ff;
    logic [7:0]  sustainRelease_ff;

    // Address decode
    logic        hit;
    logic [15:0] regOffset;
    logic [2:0]  regIdx;

    assign hit       = wrEn && (wrAddr >= VOICE_BASE_ADDR)
                            && (wrAddr <= VOICE_LAST_ADDR);
    assign regOffset = wrAddr - VOICE_BASE_ADDR;
    assign regIdx    = regOffset[2:0];

    // Byte registers; writes outside the voice window are ignored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            noteLowByte_ff    <= REG_RESET;
            noteHighByte_ff   <= REG_RESET;
            pwLow_ff          <= REG_RESET;
            pwHigh_ff         <= REG_RESET;
            control_ff        <= REG_RESET;
            attackDecay_ff    <= REG_RESET;
            sustainRelease_ff <= REG_RESET;
        end else if (hit) begin
            case (regIdx)
                OFS_FREQ_LOW:     noteLowByte_ff    <= wrData;
                OFS_FREQ_HIGH:    noteHighByte_ff   <= wrData;
                OFS_PW_LOW:       pwLow_ff          <= wrData;
                OFS_PW_HIGH:      pwHigh_ff         <= wrData;
                OFS_CONTROL:      control_ff        <= wrData;
                OFS_ATTACK_DECAY: attackDecay_ff    <= wrData;
                OFS_SUSTAIN_REL:  sustainRelease_ff <= wrData;
                default: ;
            endcase
        end
    end

    // Field extraction
    logic [15:0] freqWord;
    logic [11:0] pulseWidth;
    logic [3:0]  attackCode;
    logic [3:0]  decayCode;
    logic [3:0]  sustainCode;
    logic [3:0]  releaseCode;
    logic        gate;

    // Note bytes may arrive in either order; the word is used live
    assign freqWord    = 16'(noteHighByte_ff * FREQ_HIGH_WEIGHT)
                       + {8'h00, noteLowByte_ff};
    assign pulseWidth  = {pwHigh_ff[3:0], pwLow_ff};
    assign attackCode  = attackDecay_ff[NIB_HI_MSB:NIB_HI_LSB];
    assign decayCode   = attackDecay_ff[NIB_LO_MSB:NIB_LO_LSB];
    assign sustainCode = sustainRelease_ff[NIB_HI_MSB:NIB_HI_LSB];
    assign releaseCode = sustainRelease_ff[NIB_LO_MSB:NIB_LO_LSB];
    assign gate        = control_ff[CTL_GATE_BIT];

    // Tick divider: one enable pulse per microsecond
    logic [TICK_CNT_W-1:0] tickCnt_ff;
    logic                  tick_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tickCnt_ff <= '0;
            tick_ff    <= 1'b0;
        end else if (tickCnt_ff == TICK_CNT_W'(TICK_CYCLES - 1)) begin
            tickCnt_ff <= '0;
            tick_ff    <= 1'b1;
        end else begin
            tickCnt_ff <= tickCnt_ff + TICK_CNT_W'(1);
            tick_ff    <= 1'b0;
        end
    end

    // Phase accumulator; pitch is linear in the frequency word
    logic [ACC_W-1:0] acc_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_ff <= ACC_RESET;
        end else if (tick_ff) begin
            acc_ff <= acc_ff + {8'h00, freqWord};
        end
    end

    // Noise shift register, stepped on a rising accumulator bit so
    // that the noise colour also follows the note
    logic [LFSR_W-1:0] lfsr_ff;
    logic              noiseClkPrev_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lfsr_ff         <= LFSR_SEED;
            noiseClkPrev_ff <= 1'b0;
        end else begin
            noiseClkPrev_ff <= acc_ff[NOISE_CLK_BIT];
            if (acc_ff[NOISE_CLK_BIT] && !noiseClkPrev_ff) begin
                lfsr_ff <= {lfsr_ff[LFSR_W-2:0],
                            lfsr_ff[22] ^ lfsr_ff[17]};
            end
        end
    end

    // Waveform select; several selected waves are ANDed together,
    // none selected gives silence
    logic [WAVE_W-1:0] triWave;
    logic [WAVE_W-1:0] sawWave;
    logic [WAVE_W-1:0] pulseWave;
    logic [WAVE_W-1:0] noiseWave;
    logic [WAVE_W-1:0] mixWave;

    assign triWave   = acc_ff[ACC_W-1] ? ~acc_ff[ACC_W-2:ACC_W-13]
                                       :  acc_ff[ACC_W-2:ACC_W-13];
    assign sawWave   = acc_ff[ACC_W-1:ACC_W-12];
    // A zero width keeps the pulse high, so the host must set one
    assign pulseWave = (acc_ff[ACC_W-1:ACC_W-12] >= pulseWidth)
                       ? '1 : '0;
    assign noiseWave = {lfsr_ff[20], lfsr_ff[18], lfsr_ff[14],
                        lfsr_ff[11], lfsr_ff[9], lfsr_ff[5],
                        lfsr_ff[2], lfsr_ff[0], 4'h0};

    always_comb begin
        mixWave = '1;
        if (control_ff[CTL_TRIANGLE_BIT]) mixWave &= triWave;
        if (control_ff[CTL_SAWTOOTH_BIT]) mixWave &= sawWave;
        if (control_ff[CTL_PULSE_BIT])    mixWave &= pulseWave;
        if (control_ff[CTL_NOISE_BIT])    mixWave &= noiseWave;
        if (control_ff[CTL_NOISE_BIT:CTL_TRIANGLE_BIT] == 4'h0) begin
            mixWave = '0;
        end
    end

    // Envelope step timer
    env_rate_if rate ();

    env_step_timer u_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .rate  (rate.timer)
    );

    // Envelope state machine
    env_state_t        state_ff;
    env_state_t        nxt_state;
    logic              gatePrev_ff;
    logic [LEVEL_W-1:0] sustainLevel;

    // Sustain nibble times 17 spans 0 to 255 linearly
    assign sustainLevel = LEVEL_W'(sustainCode * SUSTAIN_SCALE);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ENV_IDLE:    nxt_state = state_ff;
            // A retrigger at full scale must still move on to decay
            ENV_ATTACK:  if (rate.step && envLevel >= LEVEL_MAX - 8'h01)
                             nxt_state = ENV_DECAY;
            ENV_DECAY:   if (envLevel <= sustainLevel)
                             nxt_state = ENV_SUSTAIN;
            ENV_SUSTAIN: nxt_state = state_ff;
            ENV_RELEASE: if (envLevel == LEVEL_ZERO)
                             nxt_state = ENV_IDLE;
            default:     nxt_state = ENV_IDLE;
        endcase
        // Gate edges override the natural progression
        if (gate && !gatePrev_ff) begin
            nxt_state = ENV_ATTACK;
        end else if (!gate && gatePrev_ff) begin
            nxt_state = ENV_RELEASE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff    <= ENV_IDLE;
            gatePrev_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            gatePrev_ff <= gate;
        end
    end

    // Step period for the current phase; falls run three times slower
    always_comb begin
        case (state_ff)
            ENV_ATTACK:  rate.period = ATTACK_STEP[attackCode];
            ENV_DECAY:   rate.period = PERIOD_W'(FALL_SCALE *
                                       ATTACK_STEP[decayCode]);
            ENV_RELEASE: rate.period = PERIOD_W'(FALL_SCALE *
                                       ATTACK_STEP[releaseCode]);
            default:     rate.period = ATTACK_STEP[attackCode];
        endcase
    end

    assign rate.restart = (nxt_state != state_ff);
    assign rate.tick    = tick_ff;

    // Envelope level: one step per timer pulse in the moving phases
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            envLevel <= LEVEL_ZERO;
        end else if (rate.step) begin
            case (state_ff)
                ENV_ATTACK: if (envLevel != LEVEL_MAX)
                    envLevel <= envLevel + LEVEL_W'(1);
                ENV_DECAY: if (envLevel > sustainLevel)
                    envLevel <= envLevel - LEVEL_W'(1);
                ENV_RELEASE: if (envLevel != LEVEL_ZERO)
                    envLevel <= envLevel - LEVEL_W'(1);
                default: ;
            endcase
        end
    end

    // Activity flag, high from note start until release reaches zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            envActive <= 1'b0;
        end else begin
            envActive <= (nxt_state != ENV_IDLE);
        end
    end

    // Output sample: top byte of the wave scaled by envelope level
    logic [15:0] scaled;

    assign scaled = mixWave[WAVE_W-1:WAVE_W-8] * envLevel;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sampleOut <= 8'h00;
        end else begin
            sampleOut <= scaled[15:8];
        end
    end

endmodule : tone_voice_envelope

// ==== hw/voice_pkg.sv ====
// Package for one tone voice: register map, control bits, envelope
// timing tables and state type.
// Assumes a single 125 MHz clock and a byte-wide host write port.
package voice_pkg;

    // Memory map: each register sits at base plus its number
    localparam logic [15:0] VOICE_BASE_ADDR   = 16'hD400;
    localparam logic [2:0]  OFS_FREQ_LOW      = 3'h0;
    localparam logic [2:0]  OFS_FREQ_HIGH     = 3'h1;
    localparam logic [2:0]  OFS_PW_LOW        = 3'h2;
    localparam logic [2:0]  OFS_PW_HIGH       = 3'h3;
    localparam logic [2:0]  OFS_CONTROL       = 3'h4;
    localparam logic [2:0]  OFS_ATTACK_DECAY  = 3'h5;
    localparam logic [2:0]  OFS_SUSTAIN_REL   = 3'h6;
    localparam logic [15:0] VOICE_LAST_ADDR   = 16'hD406;

    // Control register bit positions
    localparam int CTL_GATE_BIT     = 0;
    localparam int CTL_TRIANGLE_BIT = 4;
    localparam int CTL_SAWTOOTH_BIT = 5;
    localparam int CTL_PULSE_BIT    = 6;
    localparam int CTL_NOISE_BIT    = 7;

    // Packed nibble fields in the envelope registers
    localparam int NIB_HI_MSB = 7;
    localparam int NIB_HI_LSB = 4;
    localparam int NIB_LO_MSB = 3;
    localparam int NIB_LO_LSB = 0;

    // Frequency word weighting of the high byte
    localparam int FREQ_HIGH_WEIGHT = 256;

    // Oscillator sample tick: time in ns and derived clock count
    localparam int CLK_PERIOD_NS    = 8;
    localparam int TICK_PERIOD_NS   = 1000;
    localparam int TICK_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_CNT_W       = 7;

    // Widths
    localparam int ACC_W    = 24;
    localparam int WAVE_W   = 12;
    localparam int LEVEL_W  = 8;
    localparam int PERIOD_W = 17;
    localparam int LFSR_W   = 23;
    localparam int NOISE_CLK_BIT = 19;

    localparam logic [ACC_W-1:0]   ACC_RESET  = 24'h00_0000;
    localparam logic [LFSR_W-1:0]  LFSR_SEED  = 23'h7F_FFF8;
    localparam logic [7:0]         REG_RESET  = 8'h00;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX  = 8'hFF;
    localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 8'h00;
    localparam logic [LEVEL_W-1:0] SUSTAIN_SCALE = 8'h11;

    // Ticks (1 us each) per envelope step of 1/256 full scale.
    // Attack spans about 2 ms at code 0 to 8 s at code 15.
    localparam logic [PERIOD_W-1:0] ATTACK_STEP [16] = '{
        17'h0_0008, 17'h0_001F, 17'h0_003E, 17'h0_005E,
        17'h0_0094, 17'h0_00DB, 17'h0_010A, 17'h0_0138,
        17'h0_0187, 17'h0_03D0, 17'h0_07A1, 17'h0_0C35,
        17'h0_0F42, 17'h0_2DC7, 17'h0_4C4B, 17'h0_7A12
    };
    // Decay and release run three times slower: 6 ms to 24 s
    localparam int FALL_SCALE = 3;

    typedef enum logic [2:0] {
        ENV_IDLE,
        ENV_ATTACK,
        ENV_DECAY,
        ENV_SUSTAIN,
        ENV_RELEASE
    } env_state_t;

endpackage : voice_pkg

// ==== sim/tone_voice_envelope_asserts.sv ====
// Port-level checker for one tone voice, bound into the design top.
// Assumes one clock and synchronous active-low rst_n.
`timescale 1ns/1ps
module tone_voice_envelope_asserts
    import voice_pkg::*;
(
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst_n,
    // Host write port
    input wire logic               wrEn,
    input wire logic [15:0]        wrAddr,
    input wire logic [7:0]         wrData,
    // Voice output
    input wire logic [7:0]         sampleOut,
    input wire logic [LEVEL_W-1:0] envLevel,
    input wire logic               envActive
);
    logic        inWin;
    logic        ctlWr;
    logic        gate_ff;
    logic [3:0]  sus_ff;
    logic        peak_ff;
    logic [15:0] gap_ff;

    // No read path exists, so gate and sustain are shadowed from writes
    assign inWin = wrEn && wrAddr >= VOICE_BASE_ADDR
                   && wrAddr <= VOICE_LAST_ADDR;
    assign ctlWr = inWin && wrAddr[2:0] == OFS_CONTROL;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_ff <= 1'b0;
            sus_ff  <= 4'h0;
        end else begin
            if (ctlWr) gate_ff <= wrData[CTL_GATE_BIT];
            if (inWin && wrAddr[2:0] == OFS_SUSTAIN_REL) sus_ff <= wrData[7:4];
        end
    end

    // Full scale seen since the last note-on
    always_ff @(posedge clk) begin
        if (!rst_n || (ctlWr && wrData[CTL_GATE_BIT] && !gate_ff)) begin
            peak_ff <= 1'b0;
        end else if (envLevel == LEVEL_MAX) begin
            peak_ff <= 1'b1;
        end
    end

    // Cycles since the level last moved; saturates to stay quiet
    always_ff @(posedge clk) begin
        if (!rst_n || $changed(envLevel)) begin
            gap_ff <= 16'h0000;
        end else if (gap_ff != 16'hFFFF) begin
            gap_ff <= gap_ff + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence noteOn;
        ctlWr && wrData[CTL_GATE_BIT] && !gate_ff;
    endsequence
    sequence strayWr;
        wrEn && !inWin && !gate_ff && !envActive;
    endsequence
    sequence levelMoved;
        $changed(envLevel);
    endsequence

    reset_clear_a: assert property (disable iff (1'b0)
        !rst_n |=> envLevel == LEVEL_ZERO && !envActive && sampleOut == 8'h00)
        else $error("outputs not cleared by reset");
    note_start_a: assert property (noteOn |-> ##2 envActive)
        else $error("gate write did not start the envelope");
    stray_write_a: assert property (strayWr |-> ##2 !envActive)
        else $error("write outside the window took effect");
    single_step_a: assert property (levelMoved |->
        envLevel == $past(envLevel) + 8'h01 ||
        envLevel == $past(envLevel) - 8'h01)
        else $error("envelope level jumped");
    step_gap_a: assert property (levelMoved |-> gap_ff >= 16'h0320)
        else $error("envelope stepped faster than the fastest rate");
    attack_rise_a: assert property (gate_ff && $past(gate_ff, 3)
        && !peak_ff && $changed(envLevel) |-> envLevel > $past(envLevel))
        else $error("level fell during attack");
    sustain_floor_a: assert property (gate_ff && $past(gate_ff, 3)
        && peak_ff && $changed(envLevel) |-> envLevel >= {sus_ff, sus_ff})
        else $error("decay passed below the sustain level");
    silent_output_a: assert property (
        envLevel == LEVEL_ZERO |=> sampleOut == 8'h00)
        else $error("sample not silent at zero level");
endmodule : tone_voice_envelope_asserts

bind tone_voice_envelope tone_voice_envelope_asserts chk (
    .clk(clk), .rst_n(rst_n), .wrEn(wrEn), .wrAddr(wrAddr),
    .wrData(wrData), .sampleOut(sampleOut), .envLevel(envLevel),
    .envActive(envActive)
);

// ==== sim/tone_voice_envelope_tb_top.sv ====
// Self-checking bench for one tone voice, driven by register writes.
// Assumes a write-only register port; state is seen on the outputs.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        totalChecks++; \
        if ((got) !== (exp)) begin \
            nFail++; \
            $display("[FAIL] %s exp %0h got %0h", nm, exp, got); \
        end \
    end
module tone_voice_envelope_tb_top
    import voice_pkg::*;
;
    logic               clk = 1'b0;
    logic               rst_n;
    logic               wrEn;
    logic [15:0]        wrAddr;
    logic [7:0]         wrData;
    logic [7:0]         sampleOut;
    logic [LEVEL_W-1:0] envLevel;
    logic               envActive;
    logic               seenNz;
    logic               seenZ;
    int                 nFail = 0;
    int                 totalChecks = 0;

    always #4 clk = ~clk;

    tone_voice_envelope dut (
        .clk(clk), .rst_n(rst_n), .wrEn(wrEn), .wrAddr(wrAddr),
        .wrData(wrData), .sampleOut(sampleOut), .envLevel(envLevel),
        .envActive(envActive)
    );

    // One-cycle write strobe, changed only at falling edges
    task automatic wrRaw(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        wrEn   = 1'b1;
        wrAddr = a;
        wrData = d;
        @(negedge clk);
        wrEn   = 1'b0;
    endtask : wrRaw

    task automatic wr(input logic [2:0] ofs, input logic [7:0] d);
        wrRaw(VOICE_BASE_ADDR + {13'h0000, ofs}, d);
    endtask : wr

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // Note whether the sample was ever zero and ever nonzero
    task automatic scan(input int n);
        seenNz = 1'b0;
        seenZ  = 1'b0;
        repeat (n) begin
            @(negedge clk);
            seenNz = seenNz | (sampleOut != 8'h00);
            seenZ  = seenZ | (sampleOut == 8'h00);
        end
    endtask : scan

    // Bounded wait; a hang shows up as a failed compare afterwards
    task automatic waitIdle(input int lim);
        int n;
        n = 0;
        while (envActive !== 1'b0 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask : waitIdle

    task automatic reportAndStop();
        if (nFail == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : reportAndStop

    // Main sequence
    initial begin
        rst_n  = 1'b0;
        wrEn   = 1'b0;
        wrAddr = 16'h0000;
        wrData = 8'h00;
        cyc(5);
        rst_n = 1'b1;
        `CHK("lvlRst", 8'h00, envLevel)
        `CHK("actRst", 1'b0, envActive)
        wrRaw(16'hD407, 8'h21);
        wrRaw(16'hD304, 8'h21);
        cyc(4);
        `CHK("actStray", 1'b0, envActive)
        wr(OFS_ATTACK_DECAY, 8'h10);
        wr(OFS_SUSTAIN_REL, 8'h80);
        wr(OFS_FREQ_HIGH, 8'h00);
        wr(OFS_FREQ_LOW, 8'hFF);
        wr(OFS_CONTROL, 8'h21);
        cyc(2);
        `CHK("actGate", 1'b1, envActive)
        cyc(3000);
        `CHK("lvlSlowAtk", 8'h00, envLevel)
        wr(OFS_CONTROL, 8'h20);
        wr(OFS_ATTACK_DECAY, 8'h01);
        wr(OFS_CONTROL, 8'h21);
        cyc(4500);
        `CHK("lvlFastAtk", 1'b1, envLevel >= 8'h03 && envLevel <= 8'h05)
        // Slowest attack freezes the level for the waveform checks
        wr(OFS_ATTACK_DECAY, 8'hF1);
        scan(12500);
        `CHK("sawLowOnly", 1'b0, seenNz)
        wr(OFS_FREQ_HIGH, 8'hFF);
        scan(16000);
        `CHK("sawHighByte", 1'b1, seenNz)
        wr(OFS_PW_HIGH, 8'h08);
        wr(OFS_CONTROL, 8'h41);
        scan(16500);
        `CHK("pulseHigh", 1'b1, seenNz)
        `CHK("pulseLow", 1'b1, seenZ)
        // Triangle is silent only near its ends, a quarter of a period
        wr(OFS_CONTROL, 8'h11);
        scan(24500);
        `CHK("triHigh", 1'b1, seenNz)
        `CHK("triLow", 1'b1, seenZ)
        `CHK("actTri", 1'b1, envActive)
        `CHK("lvlHeld", 1'b1, envLevel >= 8'h03 && envLevel <= 8'h05)
        wr(OFS_CONTROL, 8'h80);
        cyc(6000);
        `CHK("actRelease", 1'b1, envActive)
        waitIdle(20000);
        `CHK("actIdle", 1'b0, envActive)
        `CHK("lvlIdle", 8'h00, envLevel)
        reportAndStop();
    end

    // Watchdog: the sequence needs about 89k cycles
    initial begin
        #(110000 * 8);
        nFail++;
        reportAndStop();
    end
endmodule : tone_voice_envelope_tb_top
